// >>> rtl/ebca_pkg.sv
package ebca_pkg;

    // ****************************************************************
    // Register map (Wishbone byte addresses)
    // ****************************************************************
    localparam logic [3:0] ADDR_BUS_CONTROL   = 4'h0;
    localparam logic [3:0] ADDR_WAIT_CTRL_ONE = 4'h4;
    localparam logic [3:0] ADDR_WAIT_CTRL_TWO = 4'h8;
    localparam logic [3:0] ADDR_LONG_WAIT     = 4'hc;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int         WARP_BIT           = 0;
    localparam int         MUX_IO_EN_BIT      = 1;
    localparam int         LONG_WAIT_W        = 2;
    localparam logic [7:0] BUS_CONTROL_RST    = 8'h00;
    localparam logic [7:0] WAIT_CTRL_ONE_RST  = 8'hff;
    localparam logic [7:0] WAIT_CTRL_TWO_RST  = 8'hff;
    localparam logic [1:0] LONG_WAIT_RST      = 2'h3;

    // ****************************************************************
    // Access kinds and state counts
    // ****************************************************************
    typedef enum logic [2:0] {
        EBCA_K_ORDINARY = 3'h0,
        EBCA_K_LONG     = 3'h1,
        EBCA_K_DRAM     = 3'h2,
        EBCA_K_MUX_IO   = 3'h3,
        EBCA_K_PERIPH   = 3'h4,
        EBCA_K_ONCHIP   = 3'h5
    } ebca_kind_e;

    localparam logic [3:0] STATES_ONE         = 4'h1;
    localparam logic [3:0] STATES_TWO         = 4'h2;
    localparam logic [3:0] STATES_PERIPH      = 4'h3;
    localparam logic [3:0] STATES_MUX_IO      = 4'h4;
    localparam logic [2:0] ONCHIP_ROM_MODE    = 3'h2;

    // Grant owners
    typedef enum logic [1:0] {
        EBCA_OWN_CPU     = 2'h0,
        EBCA_OWN_DMA     = 2'h1,
        EBCA_OWN_REFRESH = 2'h3,
        EBCA_OWN_EXT     = 2'h2
    } ebca_owner_e;

endpackage : ebca_pkg

// >>> rtl/ebca_sync.sv
module ebca_sync #(
    parameter int          WIDTH = 1,
    parameter logic [31:0] INIT  = 32'h0
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // Data
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] stage;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage <= INIT[WIDTH-1:0];
            dout  <= INIT[WIDTH-1:0];
        end else begin
            stage <= din;
            dout  <= stage;
        end
    end

endmodule : ebca_sync

// >>> rtl/ebca_state_count.sv
module ebca_state_count (
    // Access kind and settings
    input  wire logic             is_write,
    input  wire logic [2:0]       kind,
    input  wire logic             area_wait_bit,
    input  wire logic             dram_pitch_bit,
    input  wire logic [1:0]       long_wait,
    // Result
    output logic      [3:0]       base_states,
    output logic                  wait_sampled
);

    logic [3:0] long_states;
    logic       ctl;

    // Register field 0..3 encodes one to four long waits
    assign long_states = {2'h0, long_wait} + 4'h1;
    // Write cycles: DRAM pitch comes from dram_pitch_bit, not the area bit
    assign ctl = (kind == ebca_pkg::EBCA_K_DRAM) ?
                 (is_write ? dram_pitch_bit : area_wait_bit) : area_wait_bit;

    always_comb begin
        base_states  = ebca_pkg::STATES_ONE;
        wait_sampled = 1'b0;
        case (kind)
            ebca_pkg::EBCA_K_ORDINARY: begin
                base_states  = (ctl || is_write) ? ebca_pkg::STATES_TWO : ebca_pkg::STATES_ONE;
                wait_sampled = ctl || is_write;
            end
            ebca_pkg::EBCA_K_LONG: begin
                base_states  = ebca_pkg::STATES_ONE + long_states;
                wait_sampled = ctl || is_write;
            end
            ebca_pkg::EBCA_K_DRAM: begin
                base_states  = ctl ? ebca_pkg::STATES_TWO : ebca_pkg::STATES_ONE;
                wait_sampled = ctl;
            end
            ebca_pkg::EBCA_K_MUX_IO: begin
                base_states  = ebca_pkg::STATES_MUX_IO;
                wait_sampled = 1'b1;
            end
            ebca_pkg::EBCA_K_PERIPH: begin
                base_states  = ebca_pkg::STATES_PERIPH;
                wait_sampled = 1'b0;
            end
            default: begin
                base_states  = ebca_pkg::STATES_ONE;
                wait_sampled = 1'b0;
            end
        endcase
    end

endmodule : ebca_state_count

// >>> rtl/ebca_top.sv
// Design decisions made here: the register addresses and the Wishbone register port.
module ebca_top (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Pins
    input  wire logic        ext_bus_request_n,
    output logic             bus_ack_n,
    input  wire logic        wait_n,
    input  wire logic [2:0]  boot_mode_pins,
    // Internal requesters
    input  wire logic        refresh_req,
    input  wire logic        dma_req,
    input  wire logic        dma_write,
    input  wire logic        dma_single,
    input  wire logic [2:0]  dma_area,
    input  wire logic        dma_upper,
    input  wire logic        cpu_req,
    input  wire logic        cpu_write,
    input  wire logic [2:0]  cpu_area,
    input  wire logic        cpu_upper,
    input  wire logic        int_req,
    // Completion and status
    output logic             refresh_done,
    output logic             dma_done,
    output logic             cpu_done,
    output logic             int_done,
    output logic [1:0]       owner,
    output logic             bus_busy
);

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0] bus_control_reg;
    logic [7:0] wait_ctrl_reg_one;
    logic [7:0] wait_ctrl_reg_two;
    logic [1:0] long_wait_count_reg;

    wire wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wb_wr     = wb_req && wb_we_i && wb_sel_i[0];
    wire hit_bcr   = (wb_adr_i == ebca_pkg::ADDR_BUS_CONTROL);
    wire hit_w1    = (wb_adr_i == ebca_pkg::ADDR_WAIT_CTRL_ONE);
    wire hit_w2    = (wb_adr_i == ebca_pkg::ADDR_WAIT_CTRL_TWO);
    wire hit_lw    = (wb_adr_i == ebca_pkg::ADDR_LONG_WAIT);
    logic [31:0] rd_mux;

    // Unmapped offsets read zero and still acknowledge
    always_comb begin
        if (hit_bcr) begin
            rd_mux = {24'h0, owner, bus_busy, bus_ack_n, bus_control_reg[3:0]};
        end else if (hit_w1) begin
            rd_mux = {24'h0, wait_ctrl_reg_one};
        end else if (hit_w2) begin
            rd_mux = {24'h0, wait_ctrl_reg_two};
        end else if (hit_lw) begin
            rd_mux = {30'h0, long_wait_count_reg};
        end else begin
            rd_mux = 32'h0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bus_control_reg     <= ebca_pkg::BUS_CONTROL_RST;
            wait_ctrl_reg_one   <= ebca_pkg::WAIT_CTRL_ONE_RST;
            wait_ctrl_reg_two   <= ebca_pkg::WAIT_CTRL_TWO_RST;
            long_wait_count_reg <= ebca_pkg::LONG_WAIT_RST;
            wb_ack_o            <= 1'b0;
            wb_dat_o            <= 32'h0;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req) begin
                wb_dat_o <= rd_mux;
            end
            if (wb_wr && hit_bcr) begin
                bus_control_reg <= {4'h0, wb_dat_i[3:0]};
            end
            if (wb_wr && hit_w1) begin
                wait_ctrl_reg_one <= wb_dat_i[7:0];
            end
            if (wb_wr && hit_w2) begin
                wait_ctrl_reg_two <= wb_dat_i[7:0];
            end
            if (wb_wr && hit_lw) begin
                long_wait_count_reg <= wb_dat_i[1:0];
            end
        end
    end

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic       ext_bus_request_n_s;
    logic       wait_s;
    logic [2:0] mode_s;

    ebca_sync #(.WIDTH(5), .INIT(32'h1f)) u_sync (
        .clk    (clk),
        .resetn (resetn),
        .din    ({ext_bus_request_n, wait_n, boot_mode_pins}),
        .dout   ({ext_bus_request_n_s, wait_s, mode_s})
    );

    // ****************************************************************
    // Access classification
    // ****************************************************************
    function automatic logic [2:0] classify(input logic [2:0] area, input logic upper,
                                            input logic mux_en, input logic [2:0] mode);
        if (area == 3'h5 && upper) begin
            classify = ebca_pkg::EBCA_K_PERIPH;
        end else if ((area == 3'h0 && mode == ebca_pkg::ONCHIP_ROM_MODE) ||
                     (area == 3'h7 && !upper)) begin
            classify = ebca_pkg::EBCA_K_ONCHIP;
        end else if (area == 3'h6 && !upper && mux_en) begin
            classify = ebca_pkg::EBCA_K_MUX_IO;
        end else if (area == 3'h1 && upper) begin
            classify = ebca_pkg::EBCA_K_DRAM;
        end else if (area == 3'h0 || area == 3'h2 || area == 3'h6) begin
            classify = ebca_pkg::EBCA_K_LONG;
        end else begin
            classify = ebca_pkg::EBCA_K_ORDINARY;
        end
    endfunction : classify

    // ****************************************************************
    // Arbiter and cycle sequencer
    // ****************************************************************
    typedef enum logic [1:0] {
        EBCA_IDLE    = 2'b00,
        EBCA_CYCLE   = 2'b01,
        EBCA_WAITING = 2'b11,
        EBCA_RELEASE = 2'b10
    } ebca_state_e;

    ebca_state_e state;
    logic [3:0]  cnt;
    logic        samp;
    logic        cur_ext_write;
    logic [3:0]  int_cnt;
    logic        int_busy;

    wire ext_req  = !ext_bus_request_n_s;
    wire sel_dma  = dma_req && !refresh_req;
    wire cyc_wr   = sel_dma ? dma_write : cpu_write;
    wire [2:0] cyc_area  = sel_dma ? dma_area : cpu_area;
    wire       cyc_upper = sel_dma ? dma_upper : cpu_upper;
    wire [2:0] cyc_kind  = classify(cyc_area, cyc_upper,
                                    bus_control_reg[ebca_pkg::MUX_IO_EN_BIT], mode_s);
    wire [7:0] wait_bits = cyc_wr ? wait_ctrl_reg_one : wait_ctrl_reg_two;
    wire [3:0] base_states;
    wire       wait_sampled;

    ebca_state_count u_count (
        .is_write       (cyc_wr),
        .kind           (cyc_kind),
        .area_wait_bit  (wait_bits[cyc_area]),
        .dram_pitch_bit (wait_ctrl_reg_one[1]),
        .long_wait      (long_wait_count_reg),
        .base_states    (base_states),
        .wait_sampled   (wait_sampled)
    );

    // Warp candidate: external write/single transfer lasting two states or more
    wire is_ext   = (cyc_kind != ebca_pkg::EBCA_K_PERIPH) &&
                    (cyc_kind != ebca_pkg::EBCA_K_ONCHIP);
    wire ext_wr   = is_ext && (cyc_wr || (sel_dma && dma_single));
    wire any_int  = refresh_req || dma_req || cpu_req;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state         <= EBCA_IDLE;
            cnt           <= 4'h0;
            samp          <= 1'b0;
            owner         <= ebca_pkg::EBCA_OWN_CPU;
            bus_ack_n     <= 1'b1;
            refresh_done  <= 1'b0;
            dma_done      <= 1'b0;
            cpu_done      <= 1'b0;
            cur_ext_write <= 1'b0;
        end else begin
            refresh_done <= 1'b0;
            dma_done     <= 1'b0;
            cpu_done     <= 1'b0;
            case (state)
                EBCA_IDLE: begin
                    if (ext_req) begin
                        state     <= EBCA_RELEASE;
                        bus_ack_n <= 1'b0;
                        owner     <= ebca_pkg::EBCA_OWN_EXT;
                    end else if (refresh_req) begin
                        state <= EBCA_CYCLE;
                        owner <= ebca_pkg::EBCA_OWN_REFRESH;
                        cnt   <= ebca_pkg::STATES_TWO - 4'h1;
                        samp  <= 1'b0;
                    end else if (dma_req || cpu_req) begin
                        state         <= EBCA_CYCLE;
                        owner         <= sel_dma ? ebca_pkg::EBCA_OWN_DMA
                                                 : ebca_pkg::EBCA_OWN_CPU;
                        cnt           <= base_states - 4'h1;
                        samp          <= wait_sampled;
                        cur_ext_write <= ext_wr && (base_states >= ebca_pkg::STATES_TWO);
                    end
                end
                EBCA_CYCLE: begin
                    // one clock per state, wait sampled in the last state only, when samp is set
                    if (cnt != 4'h0) begin
                        cnt <= cnt - 4'h1;
                    end else if (samp && !wait_s) begin
                        state <= EBCA_WAITING;
                    end else begin
                        state         <= EBCA_IDLE;
                        cur_ext_write <= 1'b0;
                        refresh_done  <= (owner == ebca_pkg::EBCA_OWN_REFRESH);
                        dma_done      <= (owner == ebca_pkg::EBCA_OWN_DMA);
                        cpu_done      <= (owner == ebca_pkg::EBCA_OWN_CPU);
                    end
                end
                EBCA_WAITING: begin
                    if (wait_s) begin
                        state         <= EBCA_IDLE;
                        cur_ext_write <= 1'b0;
                        dma_done      <= (owner == ebca_pkg::EBCA_OWN_DMA);
                        cpu_done      <= (owner == ebca_pkg::EBCA_OWN_CPU);
                    end
                end
                default: begin
                    // refresh raises acknowledge, bus stays out
                    if (refresh_req) begin
                        bus_ack_n <= 1'b1;
                    end
                    if (!ext_req) begin
                        state     <= EBCA_IDLE;
                        bus_ack_n <= 1'b1;
                        owner     <= ebca_pkg::EBCA_OWN_CPU;
                    end
                end
            endcase
        end
    end

    assign bus_busy = (state != EBCA_IDLE);

    // ****************************************************************
    // Internal access path, overlaps external writes in warp mode
    // ****************************************************************
    // warp allows parallel internal access
    // overlap from the second state on
    // A cycle the sequencer takes at this same edge keeps the internal path out
    wire int_go = int_req && !int_busy &&
                  ((!bus_busy && !any_int) ||
                   (bus_control_reg[ebca_pkg::WARP_BIT] && cur_ext_write &&
                    state == EBCA_CYCLE));

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            int_busy <= 1'b0;
            int_cnt  <= 4'h0;
            int_done <= 1'b0;
        end else begin
            int_done <= 1'b0;
            if (int_go) begin
                int_busy <= 1'b1;
                int_cnt  <= ebca_pkg::STATES_PERIPH - 4'h1;
            end else if (int_busy && int_cnt != 4'h0) begin
                int_cnt <= int_cnt - 4'h1;
            end else if (int_busy) begin
                int_busy <= 1'b0;
                int_done <= 1'b1;
            end
        end
    end

endmodule : ebca_top

// >>> verif/ebca_top_monitor.sv
module ebca_top_monitor (
    // Clock and reset
    input wire logic       clk,
    input wire logic       resetn,
    // Observed ports
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    input wire logic       ext_bus_request_n,
    input wire logic       bus_ack_n,
    input wire logic       refresh_req,
    input wire logic       refresh_done,
    input wire logic       dma_done,
    input wire logic       cpu_done,
    input wire logic [1:0] owner
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_released;
        !bus_ack_n ##1 !bus_ack_n;
    endsequence
    // Request pin synchroniser needs two edges to reach the grant logic
    sequence s_req_idle;
        ext_bus_request_n [*4];
    endsequence

    AST_WB_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered in one cycle");
    AST_WB_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack longer than one cycle");
    AST_GRANT_CAUSE: assert property ($fell(bus_ack_n) |-> $past(ext_bus_request_n, 2) == 1'b0)
        else $error("release without request");
    AST_GRANT_IDLE: assert property (s_released |-> !cpu_done && !dma_done && !refresh_done)
        else $error("internal cycle ended while bus released");
    AST_OWNER_EXT: assert property (s_released |-> owner == ebca_pkg::EBCA_OWN_EXT)
        else $error("owner not external while released");
    AST_REFRESH_FLAG: assert property (!bus_ack_n && refresh_req |-> ##[1:3] bus_ack_n)
        else $error("refresh not announced during release");
    AST_RETURN: assert property (s_req_idle |-> bus_ack_n)
        else $error("bus not taken back after request rose");
    AST_DONE_ONE: assert property ($onehot0({refresh_done, dma_done, cpu_done}))
        else $error("two owners finished together");
    AST_CPU_PULSE: assert property (cpu_done |=> !cpu_done)
        else $error("cpu done longer than one cycle");
endmodule : ebca_top_monitor

bind ebca_top ebca_top_monitor i_mon (
    .clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .ext_bus_request_n(ext_bus_request_n), .bus_ack_n(bus_ack_n),
    .refresh_req(refresh_req), .refresh_done(refresh_done), .dma_done(dma_done),
    .cpu_done(cpu_done), .owner(owner)
);

// >>> verif/ebca_ext_master.sv
module ebca_ext_master #(
    parameter int TIMEOUT = 40
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // Bench control
    input  wire logic       go,
    input  wire logic [7:0] hold,
    output int              grants,
    // Pins
    input  wire logic       bus_ack_n,
    output logic            ext_bus_request_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic ack_q;
    logic granted;
    int   cnt;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ext_bus_request_n <= 1'b1;
            ack_q             <= 1'b1;
            granted           <= 1'b0;
            cnt               <= 0;
            grants            <= 0;
        end else begin
            ack_q <= bus_ack_n;
            cnt   <= cnt + 1;
            if (go && ext_bus_request_n) begin
                ext_bus_request_n <= 1'b0;
                granted           <= 1'b0;
                cnt               <= 0;
            end else if (!ext_bus_request_n) begin
                if (!granted && !bus_ack_n && !ack_q) begin
                    granted <= 1'b1;
                    grants  <= grants + 1;
                    cnt     <= 0;
                end
                if (granted && (bus_ack_n || cnt >= hold))
                    ext_bus_request_n <= 1'b1;
                if (!granted && cnt >= TIMEOUT)
                    ext_bus_request_n <= 1'b1;
            end
        end
    end
endmodule : ebca_ext_master

// >>> verif/ebca_top_tb.sv
module ebca_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    // Done is seen after the states plus the request edge and the idle edge
    localparam int LAT_OFS = 2;
    logic clk = 1'b0, resetn = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0, req_q = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic wb_ack_o, ext_bus_request_n, bus_ack_n, wait_n = 1'b1, go = 1'b0, burst = 1'b0;
    logic [2:0] boot_mode_pins = 3'h5, cpu_area = 3'h0, dma_area = 3'h0, boot = 3'h5;
    logic cpu_write = 1'b0, cpu_upper = 1'b0, dma_write = 1'b0, dma_upper = 1'b0;
    logic dma_single = 1'b0, mux = 1'b0, refresh_done, dma_done, cpu_done, int_done, bus_busy;
    logic [7:0] hold = 8'h40, seed = 8'h28, wc1 = 8'hff, wc2 = 8'hff;
    logic [1:0] owner;
    wire logic [3:0] done = {refresh_done, int_done, dma_done, cpu_done};
    int lw = 3, cyc = 0, grants, err_count = 0, n_compared = 0;
    int t_done[4];
    int ord[$];

    always #12.5 clk = ~clk;

    ebca_top i_dut (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_bus_request_n(ext_bus_request_n),
        .bus_ack_n(bus_ack_n), .wait_n(wait_n), .boot_mode_pins(boot_mode_pins),
        .refresh_req(req_q[3] & !refresh_done), .dma_req(req_q[1] & !dma_done),
        .dma_write(dma_write), .dma_single(dma_single), .dma_area(dma_area),
        .dma_upper(dma_upper), .cpu_req(req_q[0] & !cpu_done), .cpu_write(cpu_write),
        .cpu_area(cpu_area), .cpu_upper(cpu_upper), .int_req(req_q[2] & !int_done),
        .refresh_done(refresh_done), .dma_done(dma_done), .cpu_done(cpu_done),
        .int_done(int_done), .owner(owner), .bus_busy(bus_busy));

    ebca_ext_master i_ext (.clk(clk), .resetn(resetn), .go(go), .hold(hold),
        .grants(grants), .bus_ack_n(bus_ack_n), .ext_bus_request_n(ext_bus_request_n));

    // ****************************************************************
    // Observation and shared tasks
    // ****************************************************************
    always @(negedge clk) begin
        cyc++;
        for (int i = 0; i < 4; i++)
            if (done[i] === 1'b1) begin
                t_done[i] = cyc;
                ord.push_back(i);
            end
    end

    // A burst keeps the DMA request up across its own completions
    always @(posedge clk)
        for (int i = 0; i < 4; i++)
            if (done[i] === 1'b1 && !(burst && i == 1))
                req_q[i] <= 1'b0;

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    function automatic int exp_states(input logic wr, input logic [2:0] a, input logic up);
        if (a == 3'h5 && up)
            return 3;
        if ((a == 3'h7 && !up) || (a == 3'h0 && boot == 3'h2))
            return 1;
        if (a == 3'h6 && !up && mux)
            return 4;
        if (a == 3'h1 && up)
            return (wr ? wc1[1] : wc2[1]) ? 2 : 1;
        if (a == 3'h0 || a == 3'h2 || a == 3'h6)
            return 2 + lw;
        return (wr || wc2[a]) ? 2 : 1;
    endfunction : exp_states

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    task automatic wb_xfer(input logic we, input logic [3:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [31:0] r);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb_xfer

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        wb_xfer(1'b1, a, d, s, r);
    endtask : wr

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] r;
        wb_xfer(1'b0, a, 32'h0, 4'hf, r);
        check("register", r, e);
    endtask : rd_chk

    task automatic access(input int w, input logic wr, input logic [2:0] a, input logic up,
                          output int lat);
        int t0;
        @(posedge clk);
        {cpu_write, cpu_area, cpu_upper} <= {wr, a, up};
        {dma_write, dma_area, dma_upper} <= {wr, a, up};
        seed = lfsr(seed);
        dma_single <= seed[0];
        req_q[w] <= 1'b1;
        t0 = cyc;
        for (int n = 0; n < 100 && t_done[w] <= t0; n++)
            @(posedge clk);
        lat = t_done[w] - t0;
    endtask : access

    task automatic check_order();
        check("order size", ord.size(), 3);
        for (int i = 0; i < 3; i++)
            check("order", ord[i], (i == 0) ? 3 : 2 - i);
    endtask : check_order

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        finish_test();
    end

    initial begin
        int lat;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        rd_chk(4'h0, 32'h10);
        rd_chk(4'h4, 32'hff);
        rd_chk(4'h8, 32'hff);
        rd_chk(4'hc, 32'h3);
        wr(4'hc, 32'h0, 4'h0);
        wr(4'h2, 32'hff, 4'hf);
        rd_chk(4'hc, 32'h3);
        rd_chk(4'h2, 32'h0);
        for (int p = 0; p < 2; p++) begin
            seed = lfsr(seed);
            wc1 = seed;
            seed = lfsr(seed);
            wc2 = seed;
            seed = lfsr(seed);
            lw = seed[1:0];
            mux = p[0];
            boot = p[0] ? 3'h2 : 3'h5;
            boot_mode_pins <= boot;
            wr(4'h4, {24'h0, wc1}, 4'hf);
            wr(4'h8, {24'h0, wc2}, 4'hf);
            wr(4'hc, 32'(lw), 4'hf);
            wr(4'h0, {30'h0, mux, 1'b0}, 4'hf);
            rd_chk(4'hc, 32'(lw));
            for (int k = 0; k < 32; k++) begin
                access(p, k[4], k[2:0], k[3], lat);
                check("states", lat, exp_states(k[4], k[2:0], k[3]) + LAT_OFS);
            end
        end
        wait_n <= 1'b0;
        access(0, 1'b0, 3'h5, 1'b1, lat);
        check("periph wait", lat, 3 + LAT_OFS);
        fork
            access(0, 1'b0, 3'h6, 1'b0, lat);
            begin
                repeat (12) @(posedge clk);
                wait_n <= 1'b1;
            end
        join
        check("mux wait", 32'(lat > 12 && lat < 24), 32'h1);
        ord.delete();
        @(posedge clk);
        req_q <= 4'b1011;
        repeat (40) @(posedge clk);
        check_order();
        burst = 1'b1;
        req_q[1] <= 1'b1;
        repeat (6) @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        for (int n = 0; n < 40 && bus_ack_n !== 1'b0; n++)
            @(posedge clk);
        check("released", bus_ack_n, 1'b0);
        burst = 1'b0;
        ord.delete();
        req_q[0] <= 1'b1;
        repeat (3) @(posedge clk);
        req_q[3] <= 1'b1;
        repeat (3) @(posedge clk);
        check("refresh flag", bus_ack_n, 1'b1);
        repeat (40) @(posedge clk);
        check("grants", grants, 1);
        check_order();
        wr(4'hc, 32'h3, 4'hf);
        for (int wp = 0; wp < 2; wp++) begin
            wr(4'h0, {30'h0, mux, wp[0]}, 4'hf);
            t_done[2] = 0;
            fork
                access(0, 1'b1, 3'h2, 1'b0, lat);
                begin
                    @(posedge clk);
                    req_q[2] <= 1'b1;
                end
            join
            repeat (12) @(posedge clk);
            check("warp", 32'(t_done[2] > 0 && t_done[2] < t_done[0]), 32'(wp));
        end
        finish_test();
    end
endmodule : ebca_top_tb
